// File: src/rtw_pkg.sv
// rtw_pkg: register map, field layout and timing constants of the clock access and power window block
// Function
// - reading either alarm window byte steps the alarm pointer down.
// - reading either time window byte steps the time pointer down.
// - only reads of value windows step pointers through the read path.
// - timekeeping writes are ignored unless the timer write enable is set.
// - write enable sets only right after the 0x55 then 0xaa key writes.
// - two-bit clock select picks secondary, low power rc, 50 hz or 60 hz.
// - stability length counts that many power control clock periods, 0 to 255.
// - with enable set, the stability timer restarts on every alarm event.
// - sample length all ones keeps the sample window always active.
// - other sample lengths last that many power control clock periods.
// - with enable set, the sample timer starts when stability window ends.
// - stability length zero starts the sample timer straight from alarm events.
// - window timer register holds stability in 15:8 and sample in 7:0.
// - alarm pointer in config bits 9:8 selects the alarm register pair.
// - writing the alarm high byte steps the alarm pointer down to zero.
// - time pointer in calibration bits 9:8 selects the timekeeping pair.
// - writing the time high byte with write enable set steps the time pointer down to zero.
package rtw_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] ADDR_CALIB   = 4'h0;
  localparam logic [3:0] ADDR_TIMEWIN = 4'h1;
  localparam logic [3:0] ADDR_ALCFG   = 4'h2;
  localparam logic [3:0] ADDR_ALWIN   = 4'h3;
  localparam logic [3:0] ADDR_PWRCTL  = 4'h4;
  localparam logic [3:0] ADDR_PWTIMER = 4'h5;
  localparam logic [3:0] ADDR_KEY     = 4'h6;
  localparam logic [3:0] ADDR_STATUS  = 4'h7;

  localparam int unsigned WREN_BIT = 13;
  localparam int unsigned PTR_LSB  = 8;
  localparam int unsigned CLKSEL_LSB = 10;
  localparam int unsigned POWER_CONTROL_ENABLE_BIT  = 15;
  localparam int unsigned STAB_LSB   = 8;
  localparam int unsigned SAMP_LSB   = 0;

  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam logic [7:0] LEN_ALL_ONES = 8'hff;
  localparam logic [15:0] PWTIMER_RST = 16'h0000;
  localparam logic [15:0] UNMAPPED_RD = 16'h0000;

  localparam logic [1:0] CLK_SOSC  = 2'h0;
  localparam logic [1:0] CLK_LOW_POWER_RC_OSC  = 2'h1;
  localparam logic [1:0] CLK_EXT50 = 2'h2;
  localparam logic [1:0] CLK_EXT60 = 2'h3;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [15:0] wdata;
  } rtw_bus_t;

  typedef enum logic [2:0] {
    KS_IDLE = 3'b001,
    KS_GOT1 = 3'b010,
    KS_OPEN = 3'b100
  } rtw_key_t;

  typedef enum logic [2:0] {
    PW_IDLE = 3'b001,
    PW_STAB = 3'b010,
    PW_SAMP = 3'b100
  } rtw_pw_t;

  function automatic logic [1:0] ptr_dec(input logic [1:0] p);
    return (p == 2'h0) ? 2'h0 : p - 2'h1;
  endfunction
endpackage

// File: src/rtw_keylock.sv
// rtw_keylock: unlock key sequencer that opens a one-access window for the write enable
`timescale 1ns/1ps
`default_nettype none
module rtw_keylock import rtw_pkg::*; (
  input  wire logic        i_ref_clk,  // core clock
  input  wire logic        i_resetn,   // sync reset, active low
  input  wire logic        i_key_wr,   // write to key register
  input  wire logic [7:0]  i_key_data, // key byte
  input  wire logic        i_any_wr,   // any register read or write
  output logic             o_open      // next access may set enable
);
  rtw_key_t st_q;
  rtw_key_t st_d;

  // any other access between key writes or after them closes the window
  always_comb begin
    st_d = KS_IDLE;
    case (st_q)
      KS_IDLE: st_d = (i_key_wr && i_key_data == KEY_FIRST) ? KS_GOT1 : KS_IDLE;
      KS_GOT1: st_d = (i_key_wr && i_key_data == KEY_SECOND) ? KS_OPEN :
                      (i_key_wr && i_key_data == KEY_FIRST) ? KS_GOT1 : KS_IDLE;
      KS_OPEN: st_d = (i_key_wr && i_key_data == KEY_FIRST) ? KS_GOT1 : KS_IDLE;
      default: st_d = KS_IDLE;
    endcase
    if (!i_any_wr && st_q != KS_IDLE)
      st_d = st_q;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) st_q <= KS_IDLE;
    else           st_q <= st_d;
  end

  assign o_open = (st_q == KS_OPEN);

  property p_open_after_keys;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (i_key_wr && i_key_data == KEY_FIRST) ##1 (i_key_wr && i_key_data == KEY_SECOND)
      |=> o_open;
  endproperty
  a_open_after_keys: assert property (p_open_after_keys) else $error("key pair did not open");
endmodule // rtw_keylock
`default_nettype wire

// File: src/rtw_window.sv
// rtw_window: stability then sample window timers driven by alarm events
`timescale 1ns/1ps
`default_nettype none
module rtw_window import rtw_pkg::*; (
  input  wire logic       i_ref_clk,  // core clock
  input  wire logic       i_resetn,   // sync reset, active low
  input  wire logic       i_tick,     // one power control clock period, pulse
  input  wire logic       i_alarm,    // alarm event pulse
  input  wire logic       i_enable,   // power control enable
  input  wire logic [7:0] i_stab_len, // stability length
  input  wire logic [7:0] i_samp_len, // sample length
  output logic            o_stab,     // stability window active
  output logic            o_samp      // sample window active
);
  rtw_pw_t    st_q;
  rtw_pw_t    st_d;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  wire        samp_forever = (i_samp_len == LEN_ALL_ONES);
  wire        stab_zero    = (i_stab_len == 8'h00);
  wire        last_tick    = i_tick && (cnt_q == 8'h01);

  always_comb begin
    st_d  = st_q;
    cnt_d = (i_tick && cnt_q != 8'h00) ? cnt_q - 8'h01 : cnt_q;
    case (st_q)
      PW_STAB: if (last_tick) begin
        st_d  = (i_samp_len == 8'h00) ? PW_IDLE : PW_SAMP;
        cnt_d = i_samp_len;
      end
      PW_SAMP: if (last_tick) st_d = PW_IDLE;
      default: st_d = PW_IDLE;
    endcase
    if (i_enable && i_alarm) begin
      if (!stab_zero) begin
        st_d  = PW_STAB;
        cnt_d = i_stab_len;
      end else begin
        st_d  = (i_samp_len == 8'h00) ? PW_IDLE : PW_SAMP;
        cnt_d = i_samp_len;
      end
    end
    if (!i_enable) st_d = PW_IDLE;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      st_q  <= PW_IDLE;
      cnt_q <= 8'h00;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // all ones wins regardless of enable
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_stab <= 1'b0;
      o_samp <= 1'b0;
    end else begin
      o_stab <= (st_d == PW_STAB);
      o_samp <= samp_forever || (st_d == PW_SAMP);
    end
  end

  property p_forever;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      samp_forever ##1 samp_forever |-> o_samp;
  endproperty
  a_forever: assert property (p_forever) else $error("all ones sample not active");
  property p_disable_drop;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (!i_enable && !samp_forever) |=> !o_samp && !o_stab;
  endproperty
  a_disable_drop: assert property (p_disable_drop) else $error("window held while disabled");
  property p_alarm_start;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (i_enable && i_alarm && !stab_zero) |=> o_stab;
  endproperty
  a_alarm_start: assert property (p_alarm_start) else $error("alarm did not start stability");
  property p_direct_samp;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (i_enable && i_alarm && stab_zero && i_samp_len != 8'h00) |=> o_samp && !o_stab;
  endproperty
  a_direct_samp: assert property (p_direct_samp) else $error("sample not started directly");
  property p_stab_to_samp;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (st_q == PW_STAB && last_tick && i_enable && !i_alarm && i_samp_len != 8'h00) |=> o_samp;
  endproperty
  a_stab_to_samp: assert property (p_stab_to_samp) else $error("sample did not follow");
  c_stab: cover property (@(posedge i_ref_clk) disable iff (!i_resetn) o_stab ##[1:300] o_samp);
  c_forever: cover property (@(posedge i_ref_clk) disable iff (!i_resetn) samp_forever && !i_enable);
endmodule // rtw_window
`default_nettype wire

// File: src/rtw_top.sv
// rtw_top: register access, write lock, clock select and power window control
`timescale 1ns/1ps
`default_nettype none
module rtw_top import rtw_pkg::*; (
  input  wire logic         i_ref_clk,   // 250 mhz core clock
  input  wire logic         i_resetn,    // sync reset, active low
  input  wire logic [3:0]   i_addr,      // register index
  input  wire logic [15:0]  i_wdata,     // write data
  input  wire logic         i_wr,        // write strobe
  input  wire logic         i_rd,        // read strobe
  output logic      [15:0]  o_rdata,     // read data, cycle after strobe
  input  wire logic [15:0]  i_time_data, // calendar pair at time pointer
  input  wire logic [15:0]  i_alarm_data,// alarm pair at alarm pointer
  output logic      [1:0]   o_time_ptr,  // time pointer
  output logic      [1:0]   o_alarm_ptr, // alarm pointer
  output logic              o_time_wr,   // accepted timekeeping write pulse
  output logic      [15:0]  o_time_wdata,// timekeeping write data
  output logic              o_alarm_wr,  // alarm value write pulse
  output logic      [15:0]  o_alarm_wdata,// alarm write data
  output logic      [1:0]   o_clk_sel,   // reference clock select
  input  wire logic         i_pwc_tick,  // power control clock pulse, same domain
  input  wire logic         i_alarm_evt, // alarm event pulse, same domain
  output logic              o_stab_active,// stability window active
  output logic              o_samp_active // sample window active
);
  rtw_bus_t   bus;
  logic [15:0] calib_q;
  logic [15:0] alcfg_q;
  logic [15:0] pwrctl_q;
  logic [15:0] pwtimer_q;
  logic [15:0] rdata_q;
  logic        key_open;

  assign bus = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};

  wire hit_calib   = (bus.addr == ADDR_CALIB);
  wire hit_timewin = (bus.addr == ADDR_TIMEWIN);
  wire hit_alcfg   = (bus.addr == ADDR_ALCFG);
  wire hit_alwin   = (bus.addr == ADDR_ALWIN);
  wire hit_pwrctl  = (bus.addr == ADDR_PWRCTL);
  wire hit_pwtimer = (bus.addr == ADDR_PWTIMER);
  wire hit_key     = (bus.addr == ADDR_KEY);
  wire hit_status  = (bus.addr == ADDR_STATUS);

  wire       wren       = calib_q[WREN_BIT];
  wire [1:0] time_ptr   = calib_q[PTR_LSB +: 2];
  wire [1:0] alarm_ptr  = alcfg_q[PTR_LSB +: 2];
  wire       pw_enable  = pwrctl_q[POWER_CONTROL_ENABLE_BIT];
  wire       alwin_pw   = (alarm_ptr == 2'h3);
  wire       time_wr_ok = bus.wr && hit_timewin && wren;
  wire       time_rd    = bus.rd && hit_timewin;
  wire       alarm_rd   = bus.rd && hit_alwin;
  wire       alarm_wr   = bus.wr && hit_alwin;
  wire       stab_bit, samp_bit;

  // core cannot tell byte from word, so any window read steps the pointer
  wire       time_step  = time_rd || time_wr_ok;
  wire       alarm_step = alarm_rd || alarm_wr;
  // wren may be set only while the key window is open; clear always allowed
  wire       wren_next  = bus.wdata[WREN_BIT] && (wren || key_open);

  rtw_keylock i_rtw_keylock (
    .i_ref_clk  (i_ref_clk),
    .i_resetn   (i_resetn),
    .i_key_wr   (bus.wr && hit_key),
    .i_key_data (bus.wdata[7:0]),
    .i_any_wr   (bus.wr || bus.rd),
    .o_open     (key_open)
  );

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      calib_q <= 16'h0000;
    end else if (bus.wr && hit_calib) begin
      calib_q          <= bus.wdata;
      calib_q[WREN_BIT] <= wren_next;
    end else if (time_step) begin
      calib_q[PTR_LSB +: 2] <= ptr_dec(time_ptr);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn)                  alcfg_q <= 16'h0000;
    else if (bus.wr && hit_alcfg)   alcfg_q <= bus.wdata;
    else if (alarm_step)            alcfg_q[PTR_LSB +: 2] <= ptr_dec(alarm_ptr);
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn)                pwrctl_q <= 16'h0000;
    else if (bus.wr && hit_pwrctl) pwrctl_q <= bus.wdata;
  end

  // window lengths also writable through alarm window at pointer 11
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn)                   pwtimer_q <= PWTIMER_RST;
    else if (bus.wr && hit_pwtimer)  pwtimer_q <= bus.wdata;
    else if (alarm_wr && alwin_pw)   pwtimer_q <= bus.wdata;
  end

  wire [15:0] status_word = {12'h000, stab_bit, samp_bit, wren, key_open};
  wire [15:0] alwin_word  = alwin_pw ? pwtimer_q : i_alarm_data;
  wire [15:0] rd_mux =
      hit_calib   ? calib_q :
      hit_timewin ? i_time_data :
      hit_alcfg   ? alcfg_q :
      hit_alwin   ? alwin_word :
      hit_pwrctl  ? pwrctl_q :
      hit_pwtimer ? pwtimer_q :
      hit_status  ? status_word : UNMAPPED_RD;

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn)  rdata_q <= 16'h0000;
    else if (bus.rd) rdata_q <= rd_mux;
    else            rdata_q <= 16'h0000;
  end

  rtw_window i_rtw_window (
    .i_ref_clk  (i_ref_clk),
    .i_resetn   (i_resetn),
    .i_tick     (i_pwc_tick),
    .i_alarm    (i_alarm_evt),
    .i_enable   (pw_enable),
    .i_stab_len (pwtimer_q[STAB_LSB +: 8]),
    .i_samp_len (pwtimer_q[SAMP_LSB +: 8]),
    .o_stab     (stab_bit),
    .o_samp     (samp_bit)
  );

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_time_wr     <= 1'b0;
      o_time_wdata  <= 16'h0000;
      o_alarm_wr    <= 1'b0;
      o_alarm_wdata <= 16'h0000;
    end else begin
      o_time_wr     <= time_wr_ok;
      o_time_wdata  <= bus.wdata;
      o_alarm_wr    <= alarm_wr && !alwin_pw;
      o_alarm_wdata <= bus.wdata;
    end
  end

  assign o_rdata       = rdata_q;
  assign o_time_ptr    = time_ptr;
  assign o_alarm_ptr   = alarm_ptr;
  assign o_clk_sel     = pwrctl_q[CLKSEL_LSB +: 2];
  assign o_stab_active = stab_bit;
  assign o_samp_active = samp_bit;

  property p_time_rd_dec;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (time_rd && time_ptr != 2'h0) |=> (time_ptr == $past(time_ptr) - 2'h1);
  endproperty
  a_time_rd_dec: assert property (p_time_rd_dec) else $error("time read no step");
  property p_alarm_rd_dec;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (alarm_rd && alarm_ptr != 2'h0) |=> (alarm_ptr == $past(alarm_ptr) - 2'h1);
  endproperty
  a_alarm_rd_dec: assert property (p_alarm_rd_dec) else $error("alarm read no step");
  property p_locked;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (bus.wr && hit_timewin && !wren) |=> !o_time_wr;
  endproperty
  a_locked: assert property (p_locked) else $error("locked time write passed");
  property p_ptr_floor;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (time_step && time_ptr == 2'h0) |=> time_ptr == 2'h0;
  endproperty
  a_ptr_floor: assert property (p_ptr_floor) else $error("pointer wrapped below zero");
  property p_no_late_set;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (!wren && !key_open) |=> !wren;
  endproperty
  a_no_late_set: assert property (p_no_late_set) else $error("enable set without key");
  property p_rdata_slot;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (bus.rd && hit_pwtimer) |=> o_rdata == $past(pwtimer_q);
  endproperty
  a_rdata_slot: assert property (p_rdata_slot) else $error("timer read mismatch");
  c_unlock: cover property (@(posedge i_ref_clk) disable iff (!i_resetn) key_open ##1 wren);
  c_tw: cover property (@(posedge i_ref_clk) disable iff (!i_resetn) o_time_wr);
  c_rdstep: cover property (@(posedge i_ref_clk) disable iff (!i_resetn) alarm_rd && alarm_ptr == 2'h2);
endmodule // rtw_top
`default_nettype wire

// File: test/rtw_top_tb.sv
// rtw_top_tb: self-checking bench with a behavioural register and window model
`timescale 1ns/1ps
`default_nettype none
module rtw_top_tb;
  import rtw_pkg::*;
  logic        i_ref_clk = 1'b0;
  logic        i_resetn = 1'b0;
  logic [3:0]  i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [15:0] i_time_data = 16'h0000;
  logic [15:0] i_alarm_data = 16'h0000;
  logic        i_pwc_tick = 1'b1;
  logic        i_alarm_evt = 1'b0;
  logic [15:0] o_rdata, o_time_wdata, o_alarm_wdata;
  logic [1:0]  o_time_ptr, o_alarm_ptr, o_clk_sel;
  logic        o_time_wr, o_alarm_wr, o_stab_active, o_samp_active;
  int          failures = 0;
  int          compares = 0;
  // model state
  int          wren = 0, tptr = 0, aptr = 0, timer = 0, en = 0, clk = 0, key = 0;
  logic [15:0] cases [7] = '{16'h0305, 16'h0004, 16'h0600, 16'h0101, 16'hfffe,
                             16'h0000, 16'h0000};

  rtw_top i_rtw_top (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_time_data(i_time_data), .i_alarm_data(i_alarm_data), .o_time_ptr(o_time_ptr),
    .o_alarm_ptr(o_alarm_ptr), .o_time_wr(o_time_wr), .o_time_wdata(o_time_wdata),
    .o_alarm_wr(o_alarm_wr), .o_alarm_wdata(o_alarm_wdata), .o_clk_sel(o_clk_sel),
    .i_pwc_tick(i_pwc_tick), .i_alarm_evt(i_alarm_evt), .o_stab_active(o_stab_active),
    .o_samp_active(o_samp_active));

  always #2 i_ref_clk = ~i_ref_clk;

  // ticks drop out now and then, so windows are measured in ticks, not cycles
  always @(posedge i_ref_clk) i_pwc_tick <= ($urandom % 4) != 0;

  function automatic int dec(input int p);
    return (p > 0) ? p - 1 : 0;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic post();
    chk(16'(o_time_ptr), 16'(tptr));
    chk(16'(o_alarm_ptr), 16'(aptr));
    chk(16'(o_clk_sel), 16'(clk));
  endtask

  // entered just after a rising edge; request held one cycle
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    logic ex_t, ex_a;
    ex_t = (a == ADDR_TIMEWIN) && (wren != 0);
    ex_a = (a == ADDR_ALWIN) && (aptr != 3);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    case (a)
      ADDR_CALIB: begin
        if (!d[13]) wren = 0;
        else if (key == 2) wren = 1;
        tptr = d[9:8];
      end
      ADDR_TIMEWIN: if (wren != 0) tptr = dec(tptr);
      ADDR_ALCFG: aptr = d[9:8];
      ADDR_ALWIN: begin
        if (aptr == 3) timer = d;
        aptr = dec(aptr);
      end
      ADDR_PWRCTL: begin
        en = d[15];
        clk = d[11:10];
      end
      ADDR_PWTIMER: timer = d;
      default: ;
    endcase
    if (a == ADDR_KEY && d[7:0] == KEY_FIRST) key = 1;
    else if (a == ADDR_KEY && d[7:0] == KEY_SECOND && key == 1) key = 2;
    else key = 0;
    #1;
    chk(16'(o_time_wr), 16'(ex_t));
    chk(16'(o_alarm_wr), 16'(ex_a));
    if (ex_t) chk(o_time_wdata, d);
    if (ex_a) chk(o_alarm_wdata, d);
    post();
  endtask

  task automatic rd(input logic [3:0] a);
    logic [15:0] e, m;
    e = 16'h0000;
    m = 16'hffff;
    i_time_data <= 16'($urandom);
    i_alarm_data <= 16'($urandom);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    case (a)
      ADDR_CALIB: begin
        e[13] = wren[0];
        e[9:8] = 2'(tptr);
        m = 16'h2300;
      end
      ADDR_TIMEWIN: e = i_time_data;
      ADDR_ALCFG: begin
        e[9:8] = 2'(aptr);
        m = 16'h0300;
      end
      ADDR_ALWIN: e = (aptr == 3) ? 16'(timer) : i_alarm_data;
      ADDR_PWRCTL: begin
        e[15] = en[0];
        e[11:10] = 2'(clk);
        m = 16'h8c00;
      end
      ADDR_PWTIMER: e = 16'(timer);
      ADDR_STATUS: begin
        e[2] = ((timer & 255) == 255);
        e[1] = wren[0];
        e[0] = (key == 2);
        // window flags follow alarm timing only while enabled
        if (en != 0) m = 16'hfff3;
      end
      default: ;
    endcase
    if (a == ADDR_TIMEWIN) tptr = dec(tptr);
    if (a == ADDR_ALWIN) aptr = dec(aptr);
    key = 0;
    #1;
    chk(o_rdata & m, e & m);
    post();
  endtask

  task automatic pulse_alarm();
    i_alarm_evt <= 1'b1;
    @(posedge i_ref_clk);
    i_alarm_evt <= 1'b0;
  endtask

  // counts window ticks after the last alarm event; both windows never overlap
  task automatic win(input logic [7:0] s, input logic [7:0] p, input int pre);
    int cs, cp, ov;
    cs = 0;
    cp = 0;
    ov = 0;
    wr(ADDR_PWTIMER, {s, p});
    if (pre > 0) begin
      pulse_alarm();
      repeat (pre - 1) @(posedge i_ref_clk);
    end
    pulse_alarm();
    repeat (1200) begin
      #1;
      if (o_stab_active === 1'b1 && i_pwc_tick === 1'b1) cs++;
      if (o_samp_active === 1'b1 && i_pwc_tick === 1'b1) cp++;
      if (o_stab_active === 1'b1 && o_samp_active === 1'b1) ov++;
      @(posedge i_ref_clk);
    end
    chk(16'(cs), 16'(s));
    chk(16'(cp), 16'(p));
    chk(16'(ov), 16'h0000);
  endtask

  task automatic conclude();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge i_ref_clk);
    failures++;
    conclude();
  end

  initial begin
    void'($urandom(4));
    repeat (20) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    @(posedge i_ref_clk);
    rd(ADDR_PWTIMER);
    rd(ADDR_CALIB);
    rd(4'h9);
    rd(ADDR_KEY);
    rd(ADDR_STATUS);
    // locked: bit13 refused, window write dropped
    wr(ADDR_CALIB, 16'h2300);
    wr(ADDR_TIMEWIN, 16'($urandom));
    repeat (4) rd(ADDR_TIMEWIN);
    // an access between key and set closes the window
    wr(ADDR_KEY, {8'h00, KEY_FIRST});
    wr(ADDR_KEY, {8'h00, KEY_SECOND});
    rd(ADDR_STATUS);
    rd(ADDR_PWRCTL);
    wr(ADDR_CALIB, 16'h2300);
    wr(ADDR_KEY, {8'h00, KEY_FIRST});
    wr(ADDR_KEY, {8'h00, KEY_SECOND});
    wr(ADDR_CALIB, 16'h2300);
    repeat (4) wr(ADDR_TIMEWIN, 16'($urandom));
    rd(ADDR_CALIB);
    wr(ADDR_CALIB, 16'h0300);
    rd(ADDR_TIMEWIN);
    wr(ADDR_ALCFG, 16'h0300);
    wr(ADDR_ALWIN, 16'($urandom));
    rd(ADDR_PWTIMER);
    wr(ADDR_ALCFG, 16'h0300);
    repeat (4) rd(ADDR_ALWIN);
    wr(ADDR_ALCFG, 16'h0200);
    repeat (3) wr(ADDR_ALWIN, 16'($urandom));
    rd(ADDR_ALCFG);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_PWRCTL, 16'(c << 10));
      rd(ADDR_PWRCTL);
    end
    wr(ADDR_PWRCTL, 16'h8000);
    cases[6] = {8'($urandom % 40), 8'($urandom % 40)};
    foreach (cases[k]) win(cases[k][15:8], cases[k][7:0], 0);
    win(8'h0a, 8'h02, 4);
    // disable in mid stability window drops both windows
    wr(ADDR_PWTIMER, 16'h1403);
    pulse_alarm();
    repeat (4) @(posedge i_ref_clk);
    wr(ADDR_PWRCTL, 16'h0000);
    @(posedge i_ref_clk);
    #1;
    chk(16'(o_stab_active), 16'h0000);
    chk(16'(o_samp_active), 16'h0000);
    wr(ADDR_PWTIMER, 16'h00ff);
    repeat (3) @(posedge i_ref_clk);
    #1;
    chk(16'(o_samp_active), 16'h0001);
    conclude();
  end
endmodule // rtw_top_tb
`default_nettype wire
